// *** bench/fdf_host_model.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// serial host stand-in driving the register port
// ------------------------------------------------------------
module fdf_host_model (
	// clock
	input wire logic ref_clk,
	// register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'hFF;
		reg_wdata = 8'h00;
	end
	// one-cycle write strobe, data inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	// one-cycle read strobe, data taken once settled
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd
endmodule : fdf_host_model

// *** bench/testbench.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// flags register two bench
// ------------------------------------------------------------
module testbench;
	logic ref_clk, reset, ce, reg_wr, reg_rd, first_led_output, second_led_output, dev_active;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, therm_code, trip_code;
	logic shutdown, fault_hold, protect_active, soft_reset, trip_fault_set;
	int fails = 0;
	int cmp_count = 0;
	fdf_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	fdf_flags2 dut (.ref_clk(ref_clk), .reset(reset), .ce(ce), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.first_led_output_short_det(first_led_output), .second_led_output_short_det(second_led_output), .therm_code(therm_code),
		.trip_code(trip_code), .dev_active(dev_active), .shutdown(shutdown),
		.fault_hold(fault_hold), .protect_active(protect_active), .soft_reset(soft_reset),
		.trip_fault_set(trip_fault_set));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	// hold detector levels, then return to idle and let synchronisers settle
	task automatic evt(input logic l1, input logic l2, input logic [7:0] code);
		@(posedge ref_clk);
		first_led_output <= l1;
		second_led_output <= l2;
		therm_code <= code;
		repeat (5) @(posedge ref_clk);
		first_led_output <= 1'b0;
		second_led_output <= 1'b0;
		therm_code <= 8'h64;
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : evt
	task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		host.rd(a, d);
		chk(n, e, d);
	endtask : rdchk
	initial begin
		#200000;
		fails++;
		end_of_test();
	end
	initial begin
		reset = 1'b1;
		ce = 1'b1;
		first_led_output = 1'b0;
		second_led_output = 1'b0;
		dev_active = 1'b1;
		therm_code = 8'h64;
		trip_code = 8'h00;
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		rdchk("reset value", 8'h09, fdf_pkg::RST_FLAGS2);
		rdchk("unmapped holds", 8'h0A, 8'h30);
		rdchk("flags one", 8'h08, 8'h00);
		host.wr(8'h09, 8'h8F);
		rdchk("reserved and flags ignore writes", 8'h09, 8'h00);
		host.wr(8'h09, 8'hFF);
		@(negedge ref_clk);
		chk("soft reset pulse", 8'h01, 8'(soft_reset));
		@(negedge ref_clk);
		chk("soft reset ends", 8'h00, 8'(soft_reset));
		rdchk("soft reset defaults", 8'h09, 8'h30);
		// a write taken while the clock enable is low must not land
		@(posedge ref_clk);
		ce <= 1'b0;
		host.wr(8'h09, 8'h00);
		ce <= 1'b1;
		rdchk("write frozen by ce", 8'h09, 8'h30);
		$display("test registers done");
		evt(1'b1, 1'b0, 8'h64);
		chk("shutdown on fault", 8'h01, 8'(shutdown));
		chk("hold on fault", 8'h01, 8'(fault_hold));
		rdchk("first led short", 8'h09, 8'h34);
		chk("hold cleared by read", 8'h00, 8'(fault_hold));
		rdchk("led short sticky", 8'h09, 8'h34);
		@(posedge ref_clk);
		dev_active <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("shutdown cleared", 8'h00, 8'(shutdown));
		@(posedge ref_clk);
		dev_active <= 1'b1;
		host.wr(8'h09, 8'h40);
		host.wr(8'h09, 8'h10);
		evt(1'b0, 1'b1, 8'h64);
		chk("no shutdown when disabled", 8'h00, 8'(shutdown));
		chk("protection latched", 8'h01, 8'(protect_active));
		rdchk("flags one read", 8'h08, 8'h00);
		chk("hold cleared by flags one", 8'h00, 8'(fault_hold));
		rdchk("second led short", 8'h09, 8'h18);
		@(posedge ref_clk);
		dev_active <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk("protection released", 8'h00, 8'(protect_active));
		$display("test led faults done");
		@(posedge ref_clk);
		dev_active <= 1'b1;
		host.wr(8'h09, 8'h40);
		evt(1'b0, 1'b0, 8'h05);
		rdchk("thermistor short", 8'h09, 8'h32);
		rdchk("short cleared by read", 8'h09, 8'h30);
		evt(1'b0, 1'b0, 8'hF0);
		rdchk("thermistor open", 8'h09, 8'h31);
		rdchk("open cleared by read", 8'h09, 8'h30);
		host.wr(8'h09, 8'h20);
		evt(1'b0, 1'b0, 8'h05);
		rdchk("short detect disabled", 8'h09, 8'h20);
		@(posedge ref_clk);
		dev_active <= 1'b0;
		evt(1'b0, 1'b0, 8'hF0);
		rdchk("open ignored when idle", 8'h09, 8'h20);
		$display("test thermistor done");
		@(posedge ref_clk);
		dev_active <= 1'b1;
		trip_code <= 8'h64;
		therm_code <= 8'h32;
		repeat (6) @(negedge ref_clk);
		chk("trip below point", 8'h01, 8'(trip_fault_set));
		@(posedge ref_clk);
		therm_code <= 8'h96;
		repeat (6) @(negedge ref_clk);
		chk("no trip above point", 8'h00, 8'(trip_fault_set));
		$display("test trip done");
		// second reset in mid-run, with shutdown set and enables cleared
		host.wr(8'h09, 8'h00);
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		chk("shutdown after reset", 8'h00, 8'(shutdown));
		chk("protection after reset", 8'h00, 8'(protect_active));
		rdchk("defaults after reset", 8'h09, fdf_pkg::RST_FLAGS2);
		$display("test reset done");
		end_of_test();
	end
endmodule : testbench

// *** rtl/fdf_fault_sense.sv ***
`timescale 1ns/100ps
module fdf_fault_sense #(
	parameter int CODE_W = 8,
	parameter int LSB_MV = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	// asynchronous detector inputs
	input wire logic first_led_output_short_det,
	input wire logic second_led_output_short_det,
	input wire logic [CODE_W-1:0] therm_code,
	// same-domain controls
	input wire logic [CODE_W-1:0] trip_code,
	input wire logic dev_active,
	input wire logic short_det_en,
	// qualified events
	output fdf_pkg::fdf_evt_t evt
);
	localparam logic [CODE_W-1:0] SHORT_CODE = CODE_W'(fdf_pkg::THERM_SHORT_MV / LSB_MV);
	localparam logic [CODE_W-1:0] OPEN_CODE = CODE_W'(fdf_pkg::THERM_OPEN_MV / LSB_MV);
	localparam int SW = CODE_W + 3;

	// ------------------------------------------------------------
	// two-stage synchronisers
	// ------------------------------------------------------------
	logic [SW-1:0] stg_q [fdf_pkg::SYNC_STAGES];
	logic [SW-1:0] stg_d [fdf_pkg::SYNC_STAGES];
	logic [CODE_W-1:0] code_s;
	logic live;

	genvar g;
	generate
		for (g = 0; g < fdf_pkg::SYNC_STAGES; g++) begin : g_sync
			if (g == 0) begin : g_head
				// top bit marks the chain as filled since reset
				always_comb begin
					stg_d[g] = {1'b1, second_led_output_short_det, first_led_output_short_det, therm_code};
				end
			end else begin : g_tail
				always_comb begin
					stg_d[g] = stg_q[g-1];
				end
			end
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					stg_q[g] <= '0;
				end else if (ce) begin
					stg_q[g] <= stg_d[g];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// comparators
	// ------------------------------------------------------------
	always_comb begin
		live = stg_q[fdf_pkg::SYNC_STAGES-1][CODE_W+2];
		code_s = stg_q[fdf_pkg::SYNC_STAGES-1][CODE_W-1:0];
		evt.second_led_output_short = live && stg_q[fdf_pkg::SYNC_STAGES-1][CODE_W+1];
		evt.first_led_output_short = live && stg_q[fdf_pkg::SYNC_STAGES-1][CODE_W];
		evt.therm_short = live && dev_active && short_det_en && (code_s < SHORT_CODE);
		evt.therm_open = live && dev_active && (code_s > OPEN_CODE);
		evt.therm_trip = live && dev_active && (code_s < trip_code);
	end
endmodule : fdf_fault_sense

// *** rtl/fdf_flags2.sv ***
`timescale 1ns/100ps
module fdf_flags2 #(
	parameter int CODE_W = 8,
	parameter int LSB_MV = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ce,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// detector inputs
	input wire logic first_led_output_short_det,
	input wire logic second_led_output_short_det,
	input wire logic [CODE_W-1:0] therm_code,
	input wire logic [CODE_W-1:0] trip_code,
	input wire logic dev_active,
	// device controls
	output logic shutdown,
	output logic fault_hold,
	output logic protect_active,
	output logic soft_reset,
	output logic trip_fault_set
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic shdn_en;
		logic short_en;
		logic second_led_output_f;
		logic first_led_output_f;
		logic tshort_f;
		logic topen_f;
		logic shutdown;
		logic hold;
		logic protect;
		logic srst;
		logic trip;
		logic [7:0] rdata;
	} fdf_state_t;

	fdf_state_t st_q;
	fdf_state_t st_d;
	fdf_pkg::fdf_evt_t evt;
	logic wr2;
	logic rd2;
	logic rd1;
	logic any_fault;
	logic [7:0] cur;
	logic srst_req;

	fdf_fault_sense #(
		.CODE_W(CODE_W),
		.LSB_MV(LSB_MV)
	) u_sense (
		.ref_clk(ref_clk),
		.reset(reset),
		.ce(ce),
		.first_led_output_short_det(first_led_output_short_det),
		.second_led_output_short_det(second_led_output_short_det),
		.therm_code(therm_code),
		.trip_code(trip_code),
		.dev_active(dev_active),
		.short_det_en(st_q.short_en),
		.evt(evt)
	);

	function automatic fdf_state_t fdf_defaults();
		fdf_state_t s;
		s = '0;
		s.shdn_en = fdf_pkg::RST_FAULT_SHDN_EN;
		s.short_en = fdf_pkg::RST_SHORT_DET_EN;
		return s;
	endfunction : fdf_defaults

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		wr2 = reg_wr && (reg_addr == fdf_pkg::ADDR_FLAGS2);
		rd2 = reg_rd && (reg_addr == fdf_pkg::ADDR_FLAGS2);
		rd1 = reg_rd && (reg_addr == fdf_pkg::ADDR_FLAGS1);
		srst_req = wr2 && reg_wdata[fdf_pkg::BIT_SOFT_RESET];
		cur = 8'h00;
		cur[fdf_pkg::BIT_FAULT_SHDN_EN] = st_q.shdn_en;
		cur[fdf_pkg::BIT_SHORT_DET_EN] = st_q.short_en;
		cur[fdf_pkg::BIT_SECOND_LED_OUTPUT_SHORT] = st_q.second_led_output_f;
		cur[fdf_pkg::BIT_FIRST_LED_OUTPUT_SHORT] = st_q.first_led_output_f;
		cur[fdf_pkg::BIT_THERM_SHORT] = st_q.tshort_f;
		cur[fdf_pkg::BIT_THERM_OPEN] = st_q.topen_f;
		any_fault = evt.second_led_output_short || evt.first_led_output_short || evt.therm_short
			|| evt.therm_open || evt.therm_trip;
		st_d = st_q;
		st_d.srst = 1'b0;
		st_d.trip = evt.therm_trip;
		st_d.rdata = (rd2 || rd1) ? (rd2 ? cur : 8'h00) : st_q.rdata;
		if (wr2) begin
			st_d.shdn_en = reg_wdata[fdf_pkg::BIT_FAULT_SHDN_EN];
			st_d.short_en = reg_wdata[fdf_pkg::BIT_SHORT_DET_EN];
		end
		if (rd2) begin
			st_d.tshort_f = 1'b0;
			st_d.topen_f = 1'b0;
		end
		if (rd1 || rd2) begin
			st_d.hold = 1'b0;
		end
		if (!dev_active) begin
			st_d.protect = 1'b0;
			st_d.shutdown = 1'b0;
		end
		// set wins over read and idle clears; a soft reset request still wins over set
		st_d.second_led_output_f = st_d.second_led_output_f || evt.second_led_output_short;
		st_d.first_led_output_f = st_d.first_led_output_f || evt.first_led_output_short;
		st_d.tshort_f = st_d.tshort_f || evt.therm_short;
		st_d.topen_f = st_d.topen_f || evt.therm_open;
		if (any_fault) begin
			st_d.hold = 1'b1;
			st_d.protect = 1'b1;
			st_d.shutdown = st_d.shutdown || st_q.shdn_en;
		end
		if (srst_req) begin
			st_d = fdf_defaults();
			st_d.srst = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			st_q <= fdf_defaults();
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign shutdown = st_q.shutdown;
	assign fault_hold = st_q.hold;
	assign protect_active = st_q.protect;
	assign soft_reset = st_q.srst;
	assign trip_fault_set = st_q.trip;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_srst_one_cycle: assert property (@(posedge ref_clk) disable iff (reset)
		ce && srst_req |=> soft_reset && !st_q.first_led_output_f
		&& st_q.shdn_en && st_q.short_en ##1 (!soft_reset || $past(srst_req) || !$past(ce)))
		else $error("soft reset not a one-cycle default restore");
	a_rdata_top_zero: assert property (@(posedge ref_clk) disable iff (reset)
		ce && rd2 |=> reg_rdata[7:6] == 2'b00)
		else $error("reserved or reset bit read nonzero");
	a_shdn_on_fault: assert property (@(posedge ref_clk) disable iff (reset)
		ce && any_fault && st_q.shdn_en && !(wr2 && reg_wdata[fdf_pkg::BIT_SOFT_RESET])
		|=> shutdown)
		else $error("fault did not force shutdown");
	a_shdn_disabled: assert property (@(posedge ref_clk) disable iff (reset)
		ce && !st_q.shdn_en && !shutdown |=> !shutdown)
		else $error("shutdown while disabled");
	a_protect_hold: assert property (@(posedge ref_clk) disable iff (reset)
		ce && protect_active && dev_active && !wr2 |=> protect_active)
		else $error("protection dropped while device enabled");
	a_short_gated: assert property (@(posedge ref_clk) disable iff (reset)
		ce && !st_q.short_en && !st_q.tshort_f |=> !st_q.tshort_f)
		else $error("short flagged while detection disabled");
	a_short_set: assert property (@(posedge ref_clk) disable iff (reset)
		ce && evt.therm_short && !srst_req |=> st_q.tshort_f)
		else $error("thermistor short flag not set");
	a_open_set: assert property (@(posedge ref_clk) disable iff (reset)
		ce && evt.therm_open && !srst_req |=> st_q.topen_f)
		else $error("thermistor open flag not set");
	a_hold_set: assert property (@(posedge ref_clk) disable iff (reset)
		ce && any_fault && !srst_req |=> fault_hold)
		else $error("fault did not set hold");
	a_hold_release: assert property (@(posedge ref_clk) disable iff (reset)
		ce && (rd1 || rd2) && !any_fault |=> !fault_hold)
		else $error("flags read did not release hold");
	a_protect_off: assert property (@(posedge ref_clk) disable iff (reset)
		ce && !dev_active && !any_fault |=> !protect_active && !shutdown)
		else $error("protection kept after device disabled");
	a_read_clears: assert property (@(posedge ref_clk) disable iff (reset)
		ce && rd2 && !evt.therm_open && !evt.therm_short |=> !st_q.topen_f && !st_q.tshort_f)
		else $error("read did not clear thermistor flags");
	a_led_sticky: assert property (@(posedge ref_clk) disable iff (reset)
		ce && evt.first_led_output_short && !wr2 |=> st_q.first_led_output_f ##1 (st_q.first_led_output_f || $past(wr2)))
		else $error("first_led_output short flag not sticky");
	a_first_led_output_set: assert property (@(posedge ref_clk) disable iff (reset)
		ce && evt.first_led_output_short && !srst_req |=> st_q.first_led_output_f)
		else $error("first_led_output short flag not set");
	a_second_led_output_sticky: assert property (@(posedge ref_clk) disable iff (reset)
		ce && st_q.second_led_output_f && !srst_req |=> st_q.second_led_output_f)
		else $error("second_led_output short flag lost");
	a_second_led_output_set: assert property (@(posedge ref_clk) disable iff (reset)
		ce && evt.second_led_output_short && !wr2 |=> st_q.second_led_output_f)
		else $error("second_led_output short flag not set");
	a_trip_pulse: assert property (@(posedge ref_clk) disable iff (reset)
		ce && evt.therm_trip && !srst_req |=> trip_fault_set)
		else $error("trip not reported");
	c_soft_reset: cover property (@(posedge ref_clk) disable iff (reset) soft_reset);
	c_shutdown: cover property (@(posedge ref_clk) disable iff (reset) $rose(shutdown));
	c_read_clear: cover property (@(posedge ref_clk) disable iff (reset)
		st_q.topen_f ##1 rd2 && ce ##1 !st_q.topen_f);
	c_hold_release: cover property (@(posedge ref_clk) disable iff (reset) $fell(fault_hold));
	c_trip: cover property (@(posedge ref_clk) disable iff (reset) $rose(trip_fault_set));
endmodule : fdf_flags2

// *** rtl/fdf_pkg.sv ***
package fdf_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_FLAGS1 = 8'h08;
	localparam logic [7:0] ADDR_FLAGS2 = 8'h09;
	localparam int BIT_RSVD = 7;
	localparam int BIT_SOFT_RESET = 6;
	localparam int BIT_FAULT_SHDN_EN = 5;
	localparam int BIT_SHORT_DET_EN = 4;
	localparam int BIT_SECOND_LED_OUTPUT_SHORT = 3;
	localparam int BIT_FIRST_LED_OUTPUT_SHORT = 2;
	localparam int BIT_THERM_SHORT = 1;
	localparam int BIT_THERM_OPEN = 0;
	localparam logic RST_FAULT_SHDN_EN = 1'b1;
	localparam logic RST_SHORT_DET_EN = 1'b1;
	localparam logic [7:0] RST_FLAGS2 = 8'h30;
	// ------------------------------------------------------------
	// thermistor thresholds in millivolts and synchroniser depth
	// ------------------------------------------------------------
	localparam int THERM_SHORT_MV = 100;
	localparam int THERM_OPEN_MV = 2300;
	localparam int SYNC_STAGES = 2;

	typedef struct packed {
		logic second_led_output_short;
		logic first_led_output_short;
		logic therm_short;
		logic therm_open;
		logic therm_trip;
	} fdf_evt_t;
endpackage : fdf_pkg
